// *** verilog/apc_regs.sv ***
`timescale 1ns/10ps
module apc_regs (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// Register port from the control interface
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Back-end status from the modulator
	input  wire logic        ok_pin,
	input  wire logic [4:0]  pwm_in,
	input  wire logic [4:0]  err_req,
	input  wire logic [4:0]  mute_req,
	input  wire logic [4:0]  hiz_req,
	// System controls
	output logic             pwm_automute_en,
	output logic             input_automute_en,
	output logic             unmute_thr_equal,
	output logic      [1:0]  deemph_sel,
	// Serial audio format
	output logic      [1:0]  rx_format,
	output logic      [1:0]  rx_wlen,
	output logic             rx_fmt_bad,
	// Per-channel back end
	output logic      [4:0]  chan_reset,
	output logic      [4:0]  chan_mute,
	output logic      [4:0]  audio_invert,
	output logic      [4:0]  pwm_p,
	output logic      [4:0]  pwm_n,
	output logic      [4:0]  pwm_oe
);
	logic [7:0] sysctl_r;
	logic [7:0] serfmt_r;
	logic [7:0] smute_r;
	apc_pkg::apc_chcfg_s cfg_r [apc_pkg::NCH];

	// Address to channel index, five means no channel
	function automatic logic [2:0] ch_of(input logic [7:0] a);
		case (a)
			apc_pkg::OFS_CH1: ch_of = 3'd0;
			apc_pkg::OFS_CH2: ch_of = 3'd1;
			apc_pkg::OFS_CH3: ch_of = 3'd2;
			apc_pkg::OFS_CH4: ch_of = 3'd3;
			apc_pkg::OFS_HP:  ch_of = 3'd4;
			default:          ch_of = 3'd5;
		endcase
	endfunction

	// Write and read decode
	wire [2:0] wr_ch   = ch_of(reg_addr);
	wire       wr_sys  = reg_wr && (reg_addr == apc_pkg::OFS_SYSCTL2);
	wire       wr_fmt  = reg_wr && (reg_addr == apc_pkg::OFS_SERFMT);
	wire       wr_smt  = reg_wr && (reg_addr == apc_pkg::OFS_SMUTE);
	wire [7:0] rd_ch   = (wr_ch < 3'd5) ? cfg_r[wr_ch] : 8'h00;
	wire [7:0] rd_mux  = (reg_addr == apc_pkg::OFS_SYSCTL2) ? sysctl_r :
	                     (reg_addr == apc_pkg::OFS_SERFMT)  ? serfmt_r :
	                     (reg_addr == apc_pkg::OFS_SMUTE)   ? smute_r  : rd_ch;

	// Global registers; every bit kept as written for readback
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sysctl_r <= apc_pkg::RST_REG;
			serfmt_r <= apc_pkg::RST_REG;
			smute_r  <= apc_pkg::RST_REG;
		end else begin
			if (wr_sys) sysctl_r <= reg_wdata; // [RQ5] [RQ19]
			if (wr_fmt) serfmt_r <= reg_wdata; // [RQ19]
			if (wr_smt) smute_r <= reg_wdata;  // [RQ17]
		end
	end

	// Read data, zero for unmapped offsets
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			reg_rdata <= apc_pkg::RST_REG;
		else if (reg_rd)
			reg_rdata <= rd_mux; // [RQ19]
	end

	// Format code split; reserved codes flagged
	wire [3:0] fcode   = serfmt_r[3:0];
	wire       fbad    = (fcode > apc_pkg::FMT_LAST);
	wire [1:0] fmt_nxt = fbad ? 2'd0 : 2'(fcode / 4'd3);
	wire [1:0] wl_nxt  = fbad ? 2'd0 : 2'(fcode % 4'd3);

	// System control and format outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pwm_automute_en   <= 1'b1;
			input_automute_en <= 1'b1;
			unmute_thr_equal  <= 1'b0;
			deemph_sel        <= 2'b00;
			rx_format         <= 2'b00;
			rx_wlen           <= 2'b00;
			rx_fmt_bad        <= 1'b0;
		end else begin
			pwm_automute_en   <= !sysctl_r[apc_pkg::SC_PWM_AM_DIS]; // [RQ1]
			input_automute_en <= !sysctl_r[apc_pkg::SC_IN_AM_DIS];  // [RQ2]
			unmute_thr_equal  <= sysctl_r[apc_pkg::SC_UNMUTE_EQ];   // [RQ3]
			deemph_sel        <= sysctl_r[1:0];                      // [RQ4]
			rx_format         <= fmt_nxt;                            // [RQ15]
			rx_wlen           <= wl_nxt;                             // [RQ15]
			rx_fmt_bad        <= fbad;
		end
	end

	// Soft-mute bits gathered per channel; headphone has none
	wire [4:0] smute_ch = {1'b0, smute_r[apc_pkg::SM_CH4], smute_r[apc_pkg::SM_CH3],
	                       smute_r[apc_pkg::SM_CH2], smute_r[apc_pkg::SM_CH1]}; // [RQ17]

	// One back end per channel, headphone last
	for (genvar g = 0; g < apc_pkg::NCH; g++) begin : g_ch
		apc_pkg::apc_chcfg_s c;
		assign c = cfg_r[g];
		// Config register for this channel, all bits stored
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn)
				cfg_r[g] <= apc_pkg::RST_REG;
			else if (reg_wr && wr_ch == 3'(g))
				cfg_r[g] <= reg_wdata; // [RQ6] [RQ14]
		end
		// Reset and mute qualification by the ok pin
		wire ch_rst  = c.recovery_en && err_req[g] &&
		               (!c.reset_needs_ok_pin_low || !ok_pin); // [RQ7] [RQ8]
		wire ch_mute = (mute_req[g] || smute_ch[g]) &&
		               (!c.mute_needs_ok_pin_low || !ok_pin);  // [RQ9] [RQ17]
		wire hiz     = hiz_req[g] || ch_rst;
		// Polarity swap and remap of the pair
		wire p_pol   = c.output_inversion ? !pwm_in[g] : pwm_in[g];   // [RQ10]
		wire n_pol   = c.output_remap ? !(ch_rst || ch_mute) : !p_pol; // [RQ11]
		wire low     = (ch_mute && c.drive_low_when_muted) ||
		               (hiz && c.hiz_to_low_remap);                   // [RQ12] [RQ13]
		wire oe_nxt  = !hiz || c.hiz_to_low_remap;                    // [RQ13]
		wire p_nxt   = !low && !hiz && p_pol;
		wire n_nxt   = !low && !hiz && n_pol;
		// Registered pin drive
		always_ff @(posedge mclk or negedge resetn) begin
			if (!resetn) begin
				chan_reset[g]   <= 1'b0;
				chan_mute[g]    <= 1'b0;
				audio_invert[g] <= 1'b0;
				pwm_p[g]        <= 1'b0;
				pwm_n[g]        <= 1'b0;
				pwm_oe[g]       <= 1'b0;
			end else begin
				chan_reset[g]   <= ch_rst;
				chan_mute[g]    <= ch_mute;
				audio_invert[g] <= c.output_inversion; // [RQ10]
				pwm_p[g]        <= p_nxt;
				pwm_n[g]        <= n_nxt;
				pwm_oe[g]       <= oe_nxt;
			end
		end
	end

	// Last byte written to channel three, for the readback check
	logic [7:0] ch3_wr_r;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			ch3_wr_r <= apc_pkg::RST_REG;
		else if (reg_wr && reg_addr == apc_pkg::OFS_CH3)
			ch3_wr_r <= reg_wdata;
	end

	// Checks on the register clock, off during reset
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_pwm_am;
		reg_wr && reg_addr == apc_pkg::OFS_SYSCTL2 ##1 !reg_wr
			|=> pwm_automute_en == !$past(reg_wdata[6], 2);
	endproperty
	a_pwm_am: assert property (p_pwm_am) else $error("pwm automute wrong"); // [RQ1]

	property p_in_am;
		wr_sys ##1 !reg_wr |=> input_automute_en == !$past(reg_wdata[5], 2);
	endproperty
	a_in_am: assert property (p_in_am) else $error("input automute wrong"); // [RQ2]

	property p_thr;
		wr_sys ##1 !reg_wr |=> unmute_thr_equal == $past(reg_wdata[4], 2);
	endproperty
	a_thr: assert property (p_thr) else $error("unmute threshold wrong"); // [RQ3]

	property p_deemph;
		wr_sys |=> ##1 deemph_sel == $past(reg_wdata[1:0], 2);
	endproperty
	a_deemph: assert property (p_deemph) else $error("de-emphasis wrong"); // [RQ4]

	property p_readback;
		reg_rd && !reg_wr && reg_addr == apc_pkg::OFS_CH3 |=> reg_rdata == $past(ch3_wr_r);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch"); // [RQ6]

	property p_reset_gate;
		chan_reset[0] |-> $past(cfg_r[0].recovery_en) && !($past(cfg_r[0].reset_needs_ok_pin_low) && $past(ok_pin));
	endproperty
	a_reset_gate: assert property (p_reset_gate) else $error("channel reset ungated"); // [RQ8]

	property p_mute_gate;
		$past(cfg_r[1].mute_needs_ok_pin_low) && $past(ok_pin) |-> !chan_mute[1];
	endproperty
	a_mute_gate: assert property (p_mute_gate) else $error("mute while ok pin high"); // [RQ9]

	property p_lowlow;
		chan_mute[2] && $past(cfg_r[2].drive_low_when_muted) |-> !pwm_p[2] && !pwm_n[2];
	endproperty
	a_lowlow: assert property (p_lowlow) else $error("muted outputs not low"); // [RQ12]

	property p_hiz;
		$past(hiz_req[3]) |-> pwm_oe[3] == $past(cfg_r[3].hiz_to_low_remap) && !pwm_p[3];
	endproperty
	a_hiz: assert property (p_hiz) else $error("hi-z handling wrong"); // [RQ13]

	property p_smute;
		chan_mute[3] |-> $past(mute_req[3]) || $past(smute_r[7]);
	endproperty
	a_smute: assert property (p_smute) else $error("channel four mute spurious"); // [RQ17]

	// Serial format decoding for sample codes
	property p_fmt_rj16;
		wr_fmt && reg_wdata[3:0] == 4'h0 ##1 !wr_fmt |=> rx_format == apc_pkg::APC_RJ && rx_wlen == apc_pkg::APC_W16;
	endproperty
	a_fmt_rj16: assert property (p_fmt_rj16) else $error("format code 0 decoded wrong"); // [RQ15]

	property p_fmt_i2s20;
		wr_fmt && reg_wdata[3:0] == 4'h4 ##1 !wr_fmt |=> rx_format == apc_pkg::APC_I2S && rx_wlen == apc_pkg::APC_W20;
	endproperty
	a_fmt_i2s20: assert property (p_fmt_i2s20) else $error("format code 4 decoded wrong"); // [RQ15]

	property p_fmt_lj24;
		wr_fmt && reg_wdata[3:0] == 4'h8 ##1 !wr_fmt |=> rx_format == apc_pkg::APC_LJ && rx_wlen == apc_pkg::APC_W24;
	endproperty
	a_fmt_lj24: assert property (p_fmt_lj24) else $error("format code 8 decoded wrong"); // [RQ15]

	// Channel reset and mute gating
	property p_reset_free;
		$past(cfg_r[0].recovery_en) && $past(err_req[0]) && !$past(cfg_r[0].reset_needs_ok_pin_low) |-> chan_reset[0];
	endproperty
	a_reset_free: assert property (p_reset_free) else $error("channel reset missing"); // [RQ8]

	property p_recov_off;
		!$past(cfg_r[2].recovery_en) |-> !chan_reset[2];
	endproperty
	a_recov_off: assert property (p_recov_off) else $error("reset with recovery disabled"); // [RQ7]

	property p_reset_hiz;
		chan_reset[1] && !$past(cfg_r[1].hiz_to_low_remap) |-> !pwm_oe[1] && !pwm_p[1] && !pwm_n[1];
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) else $error("reset channel still driven"); // [RQ7]

	property p_mute_free;
		$past(resetn) && $past(mute_req[1]) && !$past(cfg_r[1].mute_needs_ok_pin_low) |-> chan_mute[1];
	endproperty
	a_mute_free: assert property (p_mute_free) else $error("channel mute missing"); // [RQ9]

	property p_smute_ch1;
		$past(resetn) && $past(smute_r[0]) && !$past(cfg_r[0].mute_needs_ok_pin_low) |-> chan_mute[0];
	endproperty
	a_smute_ch1: assert property (p_smute_ch1) else $error("channel one soft mute missing"); // [RQ17]

	// Pin drive, polarity and remap
	property p_swap;
		pwm_p[0] |-> $past(pwm_in[0]) != $past(cfg_r[0].output_inversion);
	endproperty
	a_swap: assert property (p_swap) else $error("positive output polarity wrong"); // [RQ10]

	property p_invert;
		reg_wr && reg_addr == apc_pkg::OFS_CH2 ##1 !reg_wr |=> audio_invert[1] == $past(reg_wdata[4], 2);
	endproperty
	a_invert: assert property (p_invert) else $error("audio inversion wrong"); // [RQ10]

	property p_remap;
		pwm_n[1] && $past(cfg_r[1].output_remap) |-> !chan_reset[1] && !chan_mute[1];
	endproperty
	a_remap: assert property (p_remap) else $error("remapped ready output wrong"); // [RQ11]

	property p_no_remap;
		pwm_n[1] && !$past(cfg_r[1].output_remap) |-> !pwm_p[1];
	endproperty
	a_no_remap: assert property (p_no_remap) else $error("outputs not complementary"); // [RQ11]

	property p_oe_drive;
		$past(resetn) && !$past(hiz_req[2]) && !$past(err_req[2]) |-> pwm_oe[2];
	endproperty
	a_oe_drive: assert property (p_oe_drive) else $error("pair not driven"); // [RQ13]

	// Headphone channel follows the channel layout
	property p_hp_low;
		chan_mute[4] && $past(cfg_r[4].drive_low_when_muted) |-> !pwm_p[4] && !pwm_n[4];
	endproperty
	a_hp_low: assert property (p_hp_low) else $error("headphone muted outputs not low"); // [RQ14]

	property p_hp_recov;
		chan_reset[4] |-> $past(cfg_r[4].recovery_en) && $past(err_req[4]);
	endproperty
	a_hp_recov: assert property (p_hp_recov) else $error("headphone reset spurious"); // [RQ14]

	property p_hp_no_smute;
		chan_mute[4] |-> $past(mute_req[4]);
	endproperty
	a_hp_no_smute: assert property (p_hp_no_smute) else $error("headphone mute spurious"); // [RQ17]
endmodule

// *** verilog/apc_pkg.sv ***
// Summary of operation
// [RQ1] Control two D6 clear enables PWM automute
// [RQ2] Control two D5 clear enables input automute
// [RQ3] D4 clear: unmute threshold 6 dB above
// [RQ4] De-emphasis field: none, 32, 44.1, 48 kHz
// [RQ5] D3, D2 no effect; D7 reserved
// [RQ6] Channel configs at 0x05, 0x06, 0x0B, 0x0C
// [RQ7] D7 enables back-end recovery reset sequence
// [RQ8] D6 set: reset only while ok pin low
// [RQ9] D5 set: mute only while ok pin low
// [RQ10] D4 set: swap outputs, invert audio
// [RQ11] D3 set: remap outputs for power stage
// [RQ12] D2 set: both outputs low when muted
// [RQ13] D1 set: high impedance becomes low-low
// [RQ14] Headphone register shares the channel layout
// [RQ15] Format codes 0-8 pick format, length
// [RQ16] Host writes D7-D4 zero, no reserved codes
// [RQ17] Soft-mute bits D0, D1, D6, D7 per channel
// [RQ18] Host avoids soft-mute with remapped mixer
// [RQ19] Ignored bits harmless; reads return last write
package apc_pkg;
	// Register offsets
	localparam logic [7:0] OFS_SYSCTL2 = 8'h04;
	localparam logic [7:0] OFS_CH1     = 8'h05;
	localparam logic [7:0] OFS_CH2     = 8'h06;
	localparam logic [7:0] OFS_CH3     = 8'h0b;
	localparam logic [7:0] OFS_CH4     = 8'h0c;
	localparam logic [7:0] OFS_HP      = 8'h0d;
	localparam logic [7:0] OFS_SERFMT  = 8'h0e;
	localparam logic [7:0] OFS_SMUTE   = 8'h0f;
	// Values after reset
	localparam logic [7:0] RST_REG     = 8'h00;
	// System control two field positions
	localparam int SC_PWM_AM_DIS = 6;
	localparam int SC_IN_AM_DIS  = 5;
	localparam int SC_UNMUTE_EQ  = 4;
	// Soft-mute bit positions for channels one to four
	localparam int SM_CH1 = 0;
	localparam int SM_CH2 = 1;
	localparam int SM_CH3 = 6;
	localparam int SM_CH4 = 7;
	// Counts
	localparam int NCH        = 5;
	localparam int FMT_CODES  = 9;
	localparam logic [3:0] FMT_LAST = 4'h8;
	// Receive formats and word lengths
	typedef enum logic [1:0] {
		APC_RJ  = 2'b00,
		APC_I2S = 2'b01,
		APC_LJ  = 2'b10
	} apc_fmt_e;
	typedef enum logic [1:0] {
		APC_W16 = 2'b00,
		APC_W20 = 2'b01,
		APC_W24 = 2'b10
	} apc_wlen_e;
	// Channel configuration layout, D7 down to D0
	typedef struct packed {
		logic recovery_en;
		logic reset_needs_ok_pin_low;
		logic mute_needs_ok_pin_low;
		logic output_inversion;
		logic output_remap;
		logic drive_low_when_muted;
		logic hiz_to_low_remap;
		logic ignored;
	} apc_chcfg_s;
endpackage

// *** verif/apc_host.sv ***
`timescale 1ns/10ps
// Host model driving the register port
module apc_host (
	// Clock
	input  wire logic       mclk,
	// Register port
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	// Idle port at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One byte write, data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	// One byte read strobe
	task automatic rd(input logic [7:0] a);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// *** verif/audio_pwm_output_control_regs_tb_top.sv ***
`timescale 1ns/10ps
module audio_pwm_output_control_regs_tb_top;
	logic       mclk, resetn, reg_wr, reg_rd, ok_pin, rd_d;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, sm;
	logic [4:0] pwm_in, err_req, mute_req, hiz_req, smv, pins;
	logic       pwm_automute_en, input_automute_en, unmute_thr_equal, rx_fmt_bad;
	logic [1:0] deemph_sel, rx_format, rx_wlen;
	logic [4:0] chan_reset, chan_mute, audio_invert, pwm_p, pwm_n, pwm_oe;
	logic [7:0] cfg [5];
	logic [7:0] exp_q [$];
	logic [7:0] ofs [8] = '{apc_pkg::OFS_SYSCTL2, apc_pkg::OFS_CH1, apc_pkg::OFS_CH2, apc_pkg::OFS_CH3,
		apc_pkg::OFS_CH4, apc_pkg::OFS_HP, apc_pkg::OFS_SERFMT, apc_pkg::OFS_SMUTE};
	int         failures, samples_checked;

	apc_host i_apc_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
	apc_regs i_apc_regs (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ok_pin(ok_pin), .pwm_in(pwm_in),
		.err_req(err_req), .mute_req(mute_req), .hiz_req(hiz_req), .pwm_automute_en(pwm_automute_en),
		.input_automute_en(input_automute_en), .unmute_thr_equal(unmute_thr_equal), .deemph_sel(deemph_sel),
		.rx_format(rx_format), .rx_wlen(rx_wlen), .rx_fmt_bad(rx_fmt_bad), .chan_reset(chan_reset),
		.chan_mute(chan_mute), .audio_invert(audio_invert), .pwm_p(pwm_p), .pwm_n(pwm_n), .pwm_oe(pwm_oe));

	// Clock
	always #5 mclk = ~mclk;
	// Read data checked against the oldest note
	always @(posedge mclk) rd_d <= reg_rd;
	always @(negedge mclk) if (rd_d === 1'b1) chk(reg_rdata, exp_q.pop_front());

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_apc_host.rd(a);
	endtask
	// Expected {reset, mute, p, n, oe} of channel g from its config and inputs
	function automatic logic [4:0] ch_exp(input int g);
		logic [7:0] c;
		logic rs, mu, hz, pp, nn, lo;
		c = cfg[g];
		rs = c[7] & err_req[g] & (!c[6] | !ok_pin);
		mu = (mute_req[g] | smv[g]) & (!c[5] | !ok_pin);
		hz = hiz_req[g] | rs;
		pp = c[4] ^ pwm_in[g];
		nn = c[3] ? !(rs | mu) : !pp;
		lo = (mu & c[2]) | (hz & c[1]);
		return {rs, mu, !lo & !hz & pp, !lo & !hz & nn, !hz | c[1]};
	endfunction
	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		#200000;
		failures++;
		test_done();
	end
	// Main sequence
	initial begin
		{mclk, resetn, ok_pin, pwm_in, err_req, mute_req, hiz_req} = '0;
		void'($urandom(32'hfc48e78f));
		repeat (6) @(negedge mclk);
		resetn = 1'b1;
		@(negedge mclk);
		chk({6'h0, pwm_automute_en, input_automute_en}, 8'h03);
		foreach (ofs[i]) rdx(ofs[i], 8'h00);
		rdx(8'h07, 8'h00);
		for (int d = 0; d < 16; d++) begin
			sm = 8'($urandom) & 8'h7f;
			i_apc_host.wr(apc_pkg::OFS_SYSCTL2, sm);
			@(negedge mclk);
			chk({6'h0, pwm_automute_en, input_automute_en}, {6'h0, !sm[6], !sm[5]});
			chk({5'h0, unmute_thr_equal, deemph_sel}, {5'h0, sm[4], sm[1:0]});
		end
		for (int f = 0; f < 9; f++) begin
			i_apc_host.wr(apc_pkg::OFS_SERFMT, 8'(f));
			@(negedge mclk);
			chk({3'h0, rx_fmt_bad, rx_format, rx_wlen}, {4'h0, 2'(f / 3), 2'(f % 3)});
		end
		for (int it = 0; it < 40; it++) begin
			foreach (cfg[g]) begin
				cfg[g] = it[0] ? 8'($urandom) : 8'($urandom) & 8'hf7;
				i_apc_host.wr(ofs[g + 1], cfg[g]);
			end
			sm = it[0] ? 8'h00 : 8'($urandom);
			i_apc_host.wr(apc_pkg::OFS_SMUTE, sm);
			smv = {1'b0, sm[apc_pkg::SM_CH4], sm[apc_pkg::SM_CH3], sm[apc_pkg::SM_CH2], sm[apc_pkg::SM_CH1]};
			foreach (cfg[g]) rdx(ofs[g + 1], cfg[g]);
			rdx(apc_pkg::OFS_SMUTE, sm);
			repeat (6) begin
				@(negedge mclk);
				{ok_pin, pwm_in, err_req, mute_req, hiz_req} = 21'($urandom);
				@(negedge mclk);
				foreach (cfg[g]) begin
					pins = {chan_reset[g], chan_mute[g], pwm_p[g], pwm_n[g], pwm_oe[g]};
					chk({3'h0, pins}, {3'h0, ch_exp(g)});
					chk({7'h0, audio_invert[g]}, {7'h0, cfg[g][4]});
				end
			end
		end
		@(negedge mclk);
		resetn = 1'b0;
		@(negedge mclk);
		resetn = 1'b1;
		rdx(apc_pkg::OFS_CH1, 8'h00);
		chk({6'h0, pwm_automute_en, input_automute_en}, 8'h03);
		@(negedge mclk);
		test_done();
	end
endmodule
